/* swc_pkg.sv */
// Constants shared by the sleep, wake and watchdog control block.
// Assumes a 32-bit APB slave with one register per aligned word.
package swc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_INTERRUPT_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_PORTB_CHANGE_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_PORTB_FALL_ENABLES  = 8'h08;
    localparam logic [7:0] OFS_PORTB_RISE_ENABLES  = 8'h0C;
    localparam logic [7:0] OFS_PERIPH_ENABLE_ONE   = 8'h10;
    localparam logic [7:0] OFS_PERIPH_ENABLE_TWO   = 8'h14;
    localparam logic [7:0] OFS_PERIPH_ENABLE_THREE = 8'h18;
    localparam logic [7:0] OFS_PERIPH_FLAGS_ONE    = 8'h1C;
    localparam logic [7:0] OFS_PERIPH_FLAGS_TWO    = 8'h20;
    localparam logic [7:0] OFS_PERIPH_FLAGS_THREE  = 8'h24;
    localparam logic [7:0] OFS_PROCESSOR_STATUS    = 8'h28;
    localparam logic [7:0] OFS_WATCHDOG_CONTROL    = 8'h2C;
    localparam logic [7:0] OFS_CONFIG              = 8'h30;
    localparam logic [7:0] OFS_EVENT_STATUS        = 8'h34;
    localparam logic [7:0] OFS_EVENT_MASK          = 8'h38;

    // Interrupt control fields
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int ENABLES_LSB           = 3;
    // Processor status fields
    localparam int TIMEOUT_BIT           = 4;
    localparam int POWER_DOWN_BIT        = 3;
    localparam logic [7:0] STATUS_RESET  = 8'h18;
    localparam logic [7:0] STATUS_SW_MASK = 8'h07;
    // Watchdog control fields
    localparam int PERIOD_SELECT_LSB     = 1;
    localparam int SOFTWARE_WDT_BIT      = 0;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h16;
    localparam logic [7:0] WATCHDOG_CONTROL_MASK  = 8'h3F;
    localparam logic [4:0] PERIOD_SELECT_MAX      = 5'h12;
    // Configuration fields: watchdog mode [1:0], oscillator mode [3:2]
    localparam logic [7:0] CONFIG_RESET  = 8'h03;
    localparam logic [7:0] CONFIG_MASK   = 8'h0F;
    localparam logic [1:0] WDT_MODE_ON     = 2'h3;
    localparam logic [1:0] WDT_MODE_NSLEEP = 2'h2;
    localparam logic [1:0] WDT_MODE_SW     = 2'h1;
    localparam logic [1:0] OSC_MODE_OTHER  = 2'h0;
    // Event status bits
    localparam int EV_SLEEP_NOP = 0;
    localparam int EV_WAKE      = 1;
    localparam int EV_WDT       = 2;
    localparam int EV_COUNT     = 3;

    // Timing
    localparam int OST_PERIODS        = 1024;
    localparam int WDT_BASE_RATIO_DEF = 32;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    typedef enum logic [2:0] {
        ST_AWAKE, ST_ASLEEP, ST_START_UP, ST_RESUME, ST_DUMMY1, ST_DUMMY2, ST_VECTOR
    } swc_state_e;
endpackage

/* swc_sleep_wake_watchdog_control.sv */
// Sleep entry, wake-up sequencing and watchdog for a small processor core.
// Assumes core strobes and interrupt events are synchronous to pclk;
// the low-frequency oscillator level arrives from another domain.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Pending enabled interrupt before sleep turns sleep into a no-operation
// - No-operation sleep leaves watchdog counter and prescaler alone
// - No-operation sleep does not set the timeout flag
// - No-operation sleep leaves the power-down flag unchanged
// - Interrupt during or after sleep: sleep completes, device wakes immediately
// - Completed sleep clears watchdog counter and prescaler
// - Completed sleep sets timeout flag and clears power-down flag
// - Wake applies 1024 oscillator periods start-up only in crystal modes
// - After wake, global enable vectors to 0004h, else continues in line
// - Missed watchdog clear within time-out causes device reset
// - Watchdog time-out selectable from 1 ms to 256 seconds
// - Watchdog modes: always on, off in sleep, software, always off
// - Watchdog counts an independent clock that runs while core clock stops
// - A source wakes the device only with its own enable set
// - Sleep stops the core clock, low-frequency oscillator keeps running
// - Watchdog time-out in sleep wakes instead of resetting, updates flags
module swc_sleep_wake_watchdog_control #(
    parameter int WDT_BASE_RATIO = swc_pkg::WDT_BASE_RATIO_DEF,
    parameter int OST_CYCLES     = swc_pkg::OST_PERIODS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_instr,
    input  wire logic        watchdog_clear_instruction,
    input  wire logic        low_freq_internal_osc,
    input  wire logic [2:0]  core_flag_events,
    input  wire logic [7:0]  portb_change_events,
    input  wire logic [7:0]  periph_one_events,
    input  wire logic [7:0]  periph_two_events,
    input  wire logic [7:0]  periph_three_events,
    output logic             cpu_clk_run,
    output logic             sleeping,
    output logic             sleep_nop,
    output logic             exec_prefetched,
    output logic             dummy_cycle,
    output logic             vector_load,
    output logic      [15:0] vector_addr,
    output logic             watchdog_reset,
    output logic             irq
);
    swc_pkg::swc_state_e state;
    logic [7:0]  interrupt_control;
    logic [7:0]  portb_change_flags;
    logic [7:0]  portb_falling_edge_enables;
    logic [7:0]  portb_rising_edge_enables;
    logic [7:0]  peripheral_irq_enable_one;
    logic [7:0]  peripheral_irq_enable_two;
    logic [7:0]  peripheral_irq_enable_three;
    logic [7:0]  peripheral_irq_flags_one;
    logic [7:0]  peripheral_irq_flags_two;
    logic [7:0]  peripheral_irq_flags_three;
    logic [7:0]  processor_status;
    logic [7:0]  watchdog_control;
    logic [7:0]  config_reg;
    logic [swc_pkg::EV_COUNT-1:0] event_status;
    logic [swc_pkg::EV_COUNT-1:0] event_mask;
    logic [10:0] ost_count;
    logic [23:0] wdt_count;
    logic        lf_meta;
    logic        lf_sync;
    logic        lf_prev;

    logic        wr_access;
    logic        rd_setup;
    logic        pending;
    logic        sleep_take;
    logic        go_nop;
    logic        go_sleep;
    logic        wdt_active;
    logic        wdt_tick;
    logic        wdt_expire;
    logic        wake;
    logic        wdt_clear;
    logic        crystal_mode;
    logic [4:0]  period_sel;
    logic [23:0] wdt_limit;
    logic [swc_pkg::EV_COUNT-1:0] ev_set;
    logic [31:0] next_prdata;
    logic        next_slverr;

    assign wr_access = psel & penable & pready & pwrite;
    assign rd_setup  = psel & ~penable & ~pready;

    // Global enable does not gate pending
    assign pending = |(interrupt_control[5:swc_pkg::ENABLES_LSB] & interrupt_control[2:0])
                   | |(peripheral_irq_enable_one & peripheral_irq_flags_one)
                   | |(peripheral_irq_enable_two & peripheral_irq_flags_two)
                   | |(peripheral_irq_enable_three & peripheral_irq_flags_three);

    assign sleep_take = (state == swc_pkg::ST_AWAKE) & sleep_instr;
    assign go_nop     = sleep_take & pending;
    assign go_sleep   = sleep_take & ~pending;

    // Watchdog enable per mode
    always_comb begin
        unique case (config_reg[1:0])
            swc_pkg::WDT_MODE_ON:     wdt_active = 1'b1;
            swc_pkg::WDT_MODE_NSLEEP: wdt_active = (state != swc_pkg::ST_ASLEEP);
            swc_pkg::WDT_MODE_SW:     wdt_active = watchdog_control[swc_pkg::SOFTWARE_WDT_BIT];
            default:                  wdt_active = 1'b0;
        endcase
    end

    // Reserved period codes fall back to the shortest interval
    assign period_sel = (watchdog_control[5:1] > swc_pkg::PERIOD_SELECT_MAX) ? 5'h00
                      : watchdog_control[5:1];
    assign wdt_limit  = (24'(WDT_BASE_RATIO) << period_sel) - 24'h000001;

    assign wdt_tick   = lf_sync & ~lf_prev;
    assign wdt_expire = wdt_active & wdt_tick & (wdt_count >= wdt_limit);
    assign wake       = (state == swc_pkg::ST_ASLEEP) & (pending | wdt_expire);
    assign crystal_mode = (config_reg[3:2] != swc_pkg::OSC_MODE_OTHER);

    // Held clear while disabled or starting up
    assign wdt_clear = go_sleep | wake | ~wdt_active | (state == swc_pkg::ST_START_UP)
                     | ((state == swc_pkg::ST_AWAKE) & watchdog_clear_instruction);

    assign ev_set = {wdt_expire, wake, go_nop};

    // Oscillator synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_meta <= 1'b0;
            lf_sync <= 1'b0;
            lf_prev <= 1'b0;
        end else begin
            lf_meta <= low_freq_internal_osc;
            lf_sync <= lf_meta;
            lf_prev <= lf_sync;
        end
    end

    // Counter and prescaler as one chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_count <= 24'h000000;
        end else if (wdt_clear || wdt_expire) begin
            wdt_count <= 24'h000000;
        end else if (wdt_tick) begin
            wdt_count <= wdt_count + 24'h000001;
        end
    end

    // Expiry in sleep only wakes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= wdt_expire & (state != swc_pkg::ST_ASLEEP);
        end
    end

    // Sleep and wake sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= swc_pkg::ST_AWAKE;
            ost_count <= 11'h000;
        end else begin
            unique case (state)
                swc_pkg::ST_AWAKE: begin
                    if (go_sleep) begin
                        state <= swc_pkg::ST_ASLEEP;
                    end
                end
                swc_pkg::ST_ASLEEP: begin
                    if (wake) begin
                        ost_count <= 11'h000;
                        state     <= crystal_mode ? swc_pkg::ST_START_UP : swc_pkg::ST_RESUME;
                    end
                end
                swc_pkg::ST_START_UP: begin
                    ost_count <= ost_count + 11'h001;
                    if (ost_count == 11'(OST_CYCLES - 1)) begin
                        state <= swc_pkg::ST_RESUME;
                    end
                end
                swc_pkg::ST_RESUME: begin
                    state <= interrupt_control[swc_pkg::GLOBAL_IRQ_ENABLE_BIT]
                           ? swc_pkg::ST_DUMMY1 : swc_pkg::ST_AWAKE;
                end
                swc_pkg::ST_DUMMY1: begin
                    state <= swc_pkg::ST_DUMMY2;
                end
                swc_pkg::ST_DUMMY2: begin
                    state <= swc_pkg::ST_VECTOR;
                end
                swc_pkg::ST_VECTOR: begin
                    state <= swc_pkg::ST_AWAKE;
                end
                default: begin
                    state <= swc_pkg::ST_AWAKE;
                end
            endcase
        end
    end

    // Core-facing outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_run     <= 1'b1;
            sleeping        <= 1'b0;
            sleep_nop       <= 1'b0;
            exec_prefetched <= 1'b0;
            dummy_cycle     <= 1'b0;
            vector_load     <= 1'b0;
            vector_addr     <= 16'h0000;
        end else begin
            cpu_clk_run     <= ~(go_sleep | (state == swc_pkg::ST_ASLEEP & ~wake)
                                 | (wake & crystal_mode)
                                 | (state == swc_pkg::ST_START_UP
                                    & ost_count != 11'(OST_CYCLES - 1)));
            sleeping        <= go_sleep | (state == swc_pkg::ST_ASLEEP & ~wake);
            sleep_nop       <= go_nop;
            exec_prefetched <= (state == swc_pkg::ST_RESUME);
            dummy_cycle     <= (state == swc_pkg::ST_DUMMY1) | (state == swc_pkg::ST_DUMMY2);
            vector_load     <= (state == swc_pkg::ST_VECTOR);
            vector_addr     <= (state == swc_pkg::ST_VECTOR) ? swc_pkg::IRQ_VECTOR : 16'h0000;
        end
    end

    // Status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_status <= swc_pkg::STATUS_RESET;
        end else begin
            if (wr_access && paddr == swc_pkg::OFS_PROCESSOR_STATUS) begin
                processor_status[2:0] <= pwdata[2:0];
            end
            if (go_sleep) begin
                processor_status[swc_pkg::TIMEOUT_BIT]    <= 1'b1;
                processor_status[swc_pkg::POWER_DOWN_BIT] <= 1'b0;
            end else if (wdt_expire) begin
                processor_status[swc_pkg::TIMEOUT_BIT]    <= 1'b0;
            end else if ((state == swc_pkg::ST_AWAKE) && watchdog_clear_instruction) begin
                processor_status[swc_pkg::TIMEOUT_BIT]    <= 1'b1;
                processor_status[swc_pkg::POWER_DOWN_BIT] <= 1'b1;
            end
        end
    end

    // Hardware set beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control           <= 8'h00;
            portb_change_flags          <= 8'h00;
            portb_falling_edge_enables  <= 8'h00;
            portb_rising_edge_enables   <= 8'h00;
            peripheral_irq_enable_one   <= 8'h00;
            peripheral_irq_enable_two   <= 8'h00;
            peripheral_irq_enable_three <= 8'h00;
            peripheral_irq_flags_one    <= 8'h00;
            peripheral_irq_flags_two    <= 8'h00;
            peripheral_irq_flags_three  <= 8'h00;
        end else begin
            interrupt_control[7:1] <= ((wr_access && paddr == swc_pkg::OFS_INTERRUPT_CONTROL)
                                      ? pwdata[7:1] : interrupt_control[7:1])
                                    | {5'h00, core_flag_events[2:1]};
            // Summary of the port change flags
            interrupt_control[0]   <= (|portb_change_flags) | core_flag_events[0];
            portb_change_flags     <= ((wr_access && paddr == swc_pkg::OFS_PORTB_CHANGE_FLAGS)
                                      ? pwdata[7:0] : portb_change_flags) | portb_change_events;
            peripheral_irq_flags_one <= ((wr_access && paddr == swc_pkg::OFS_PERIPH_FLAGS_ONE)
                                        ? pwdata[7:0] : peripheral_irq_flags_one) | periph_one_events;
            peripheral_irq_flags_two <= ((wr_access && paddr == swc_pkg::OFS_PERIPH_FLAGS_TWO)
                                        ? pwdata[7:0] : peripheral_irq_flags_two) | periph_two_events;
            peripheral_irq_flags_three <= ((wr_access && paddr == swc_pkg::OFS_PERIPH_FLAGS_THREE)
                                          ? pwdata[7:0] : peripheral_irq_flags_three)
                                        | periph_three_events;
            if (wr_access) begin
                unique case (paddr)
                    swc_pkg::OFS_PORTB_FALL_ENABLES:  portb_falling_edge_enables  <= pwdata[7:0];
                    swc_pkg::OFS_PORTB_RISE_ENABLES:  portb_rising_edge_enables   <= pwdata[7:0];
                    swc_pkg::OFS_PERIPH_ENABLE_ONE:   peripheral_irq_enable_one   <= pwdata[7:0];
                    swc_pkg::OFS_PERIPH_ENABLE_TWO:   peripheral_irq_enable_two   <= pwdata[7:0];
                    swc_pkg::OFS_PERIPH_ENABLE_THREE: peripheral_irq_enable_three <= pwdata[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Watchdog and block configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_control <= swc_pkg::WATCHDOG_CONTROL_RESET;
            config_reg       <= swc_pkg::CONFIG_RESET;
        end else if (wr_access) begin
            if (paddr == swc_pkg::OFS_WATCHDOG_CONTROL) begin
                watchdog_control <= pwdata[7:0] & swc_pkg::WATCHDOG_CONTROL_MASK;
            end
            if (paddr == swc_pkg::OFS_CONFIG) begin
                config_reg <= pwdata[7:0] & swc_pkg::CONFIG_MASK;
            end
        end
    end

    // Write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status <= '0;
            event_mask   <= '0;
            irq          <= 1'b0;
        end else begin
            if (wr_access && paddr == swc_pkg::OFS_EVENT_STATUS) begin
                event_status <= (event_status & ~pwdata[swc_pkg::EV_COUNT-1:0]) | ev_set;
            end else begin
                event_status <= event_status | ev_set;
            end
            if (wr_access && paddr == swc_pkg::OFS_EVENT_MASK) begin
                event_mask <= pwdata[swc_pkg::EV_COUNT-1:0];
            end
            irq <= |(event_status & event_mask);
        end
    end

    // Read mux, sampled in setup
    always_comb begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        unique case (paddr)
            swc_pkg::OFS_INTERRUPT_CONTROL:   next_prdata[7:0] = interrupt_control;
            swc_pkg::OFS_PORTB_CHANGE_FLAGS:  next_prdata[7:0] = portb_change_flags;
            swc_pkg::OFS_PORTB_FALL_ENABLES:  next_prdata[7:0] = portb_falling_edge_enables;
            swc_pkg::OFS_PORTB_RISE_ENABLES:  next_prdata[7:0] = portb_rising_edge_enables;
            swc_pkg::OFS_PERIPH_ENABLE_ONE:   next_prdata[7:0] = peripheral_irq_enable_one;
            swc_pkg::OFS_PERIPH_ENABLE_TWO:   next_prdata[7:0] = peripheral_irq_enable_two;
            swc_pkg::OFS_PERIPH_ENABLE_THREE: next_prdata[7:0] = peripheral_irq_enable_three;
            swc_pkg::OFS_PERIPH_FLAGS_ONE:    next_prdata[7:0] = peripheral_irq_flags_one;
            swc_pkg::OFS_PERIPH_FLAGS_TWO:    next_prdata[7:0] = peripheral_irq_flags_two;
            swc_pkg::OFS_PERIPH_FLAGS_THREE:  next_prdata[7:0] = peripheral_irq_flags_three;
            swc_pkg::OFS_PROCESSOR_STATUS:    next_prdata[7:0] = processor_status;
            swc_pkg::OFS_WATCHDOG_CONTROL:    next_prdata[7:0] = watchdog_control;
            swc_pkg::OFS_CONFIG:              next_prdata[7:0] = config_reg;
            swc_pkg::OFS_EVENT_STATUS:        next_prdata[swc_pkg::EV_COUNT-1:0] = event_status;
            swc_pkg::OFS_EVENT_MASK:          next_prdata[swc_pkg::EV_COUNT-1:0] = event_mask;
            default:                          next_slverr = 1'b1;
        endcase
    end

    // No wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= rd_setup;
            pslverr <= rd_setup & next_slverr;
            if (rd_setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule

`default_nettype wire

/* swc_sva.sv */
// Checker for the sleep, wake and watchdog control block.
// Assumes it is bound onto the top module; one pclk domain.
`timescale 1ns/1ns
`default_nettype none
module swc_sva #(
    parameter int OST_CYCLES = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        sleep_instr,
    input  wire logic        cpu_clk_run,
    input  wire logic        sleeping,
    input  wire logic        sleep_nop,
    input  wire logic        exec_prefetched,
    input  wire logic        dummy_cycle,
    input  wire logic        vector_load,
    input  wire logic [15:0] vector_addr,
    input  wire logic        watchdog_reset
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [11:0] ost_cnt;
    // Awake cycles with the core clock held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_cnt <= 12'h000;
        end else if (cpu_clk_run || sleeping) begin
            ost_cnt <= 12'h000;
        end else begin
            ost_cnt <= ost_cnt + 12'h001;
        end
    end
    property p_nop; sleep_nop |-> $past(sleep_instr) && !sleeping && cpu_clk_run; endproperty
    property p_enter; $rose(sleeping) |-> $past(sleep_instr) && !cpu_clk_run; endproperty
    property p_clk_stop; sleeping |-> !cpu_clk_run; endproperty
    property p_wake; $rose(cpu_clk_run) |=> exec_prefetched; endproperty
    property p_ost; $rose(cpu_clk_run) && ost_cnt != 12'h000 |-> ost_cnt == 12'(OST_CYCLES); endproperty
    property p_dummy; $rose(dummy_cycle) |-> $past(exec_prefetched) ##0 dummy_cycle [*2] ##1 vector_load; endproperty
    property p_vec; vector_addr == (vector_load ? swc_pkg::IRQ_VECTOR : 16'h0000); endproperty
    property p_wdt_awake; watchdog_reset |-> !$past(sleeping); endproperty
    a_nop: assert property (p_nop) else $error("no-op pulse without awake sleep");
    a_enter: assert property (p_enter) else $error("sleep entered without instruction");
    a_clk_stop: assert property (p_clk_stop) else $error("core clock runs in sleep");
    a_wake: assert property (p_wake) else $error("no prefetched instruction after wake");
    a_ost: assert property (p_ost) else $error("start-up delay length wrong");
    a_dummy: assert property (p_dummy) else $error("vector sequence wrong");
    a_vec: assert property (p_vec) else $error("vector address wrong");
    a_wdt_awake: assert property (p_wdt_awake) else $error("reset request from sleep");
    c_nop: cover property (sleep_nop);
    c_vec: cover property (vector_load);
    c_ost: cover property ($fell(sleeping) && !cpu_clk_run);
    c_wdt: cover property (watchdog_reset);
endmodule
bind swc_sleep_wake_watchdog_control swc_sva #(.OST_CYCLES(OST_CYCLES)) u_swc_sva (
    .pclk(pclk), .presetn(presetn), .sleep_instr(sleep_instr), .cpu_clk_run(cpu_clk_run),
    .sleeping(sleeping), .sleep_nop(sleep_nop), .exec_prefetched(exec_prefetched),
    .dummy_cycle(dummy_cycle), .vector_load(vector_load), .vector_addr(vector_addr),
    .watchdog_reset(watchdog_reset));
`default_nettype wire

/* swc_core_model.sv */
// Core-side partner: instruction strobes and the low-frequency oscillator.
// Assumes pclk from the bench; strobes change just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module swc_core_model (
    input  wire logic pclk,
    output logic      sleep_instr,
    output logic      watchdog_clear_instruction,
    output logic      low_freq_internal_osc
);
    initial begin
        sleep_instr = 1'b0;
        watchdog_clear_instruction = 1'b0;
        low_freq_internal_osc = 1'b0;
    end
    // Free running and unrelated in phase to pclk
    always #37 low_freq_internal_osc = ~low_freq_internal_osc;
    task exec_sleep;
        @(posedge pclk) sleep_instr <= 1'b1;
        @(posedge pclk) sleep_instr <= 1'b0;
    endtask
    // Watchdog service
    task exec_clear;
        @(posedge pclk) watchdog_clear_instruction <= 1'b1;
        @(posedge pclk) watchdog_clear_instruction <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb_sleep_wake_watchdog_control.sv */
// Self-checking bench for the sleep, wake and watchdog control block.
// Assumes the bound checker; short watchdog and start-up counts.
`timescale 1ns/1ns
`default_nettype none
module tb_sleep_wake_watchdog_control;
    localparam logic [7:0] ST = swc_pkg::OFS_PROCESSOR_STATUS;
    localparam logic [7:0] WD = swc_pkg::OFS_WATCHDOG_CONTROL;
    localparam logic [7:0] FL = swc_pkg::OFS_PERIPH_FLAGS_ONE;
    localparam logic [7:0] CF = swc_pkg::OFS_CONFIG;
    localparam logic [7:0] ES = swc_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] IC = swc_pkg::OFS_INTERRUPT_CONTROL;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, ev = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] vector_addr;
    logic        pready, pslverr, er, sl, wc, lfo, cpu_clk_run, sleeping, sleep_nop, vec;
    logic        exec_prefetched, dummy_cycle, vector_load, watchdog_reset, irq;
    int          err_total = 0, cmp_count = 0, cyc_total = 0, k;
    always #4 pclk = ~pclk;
    swc_core_model u_core (.pclk(pclk), .sleep_instr(sl), .watchdog_clear_instruction(wc),
        .low_freq_internal_osc(lfo));
    swc_sleep_wake_watchdog_control #(.WDT_BASE_RATIO(2), .OST_CYCLES(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_instr(sl), .watchdog_clear_instruction(wc), .low_freq_internal_osc(lfo),
        .core_flag_events(3'h0), .portb_change_events(ev), .periph_one_events(ev),
        .periph_two_events(8'h00), .periph_three_events(8'h00), .cpu_clk_run(cpu_clk_run),
        .sleeping(sleeping), .sleep_nop(sleep_nop), .exec_prefetched(exec_prefetched),
        .dummy_cycle(dummy_cycle), .vector_load(vector_load), .vector_addr(vector_addr),
        .watchdog_reset(watchdog_reset), .irq(irq));
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task rdc(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rd, e); endtask
    task pulse; @(posedge pclk) ev <= 8'h01; @(posedge pclk) ev <= 8'h00; endtask
    task cyc(input int c); repeat (c) @(negedge pclk); endtask
    task automatic waitfor(ref logic s);
        for (int n = 0; s !== 1'b1 && n < 300; n++) @(negedge pclk);
        chk(32'(s), 32'h1);
    endtask
    always @(posedge pclk) begin
        cyc_total++;
        if (cyc_total == 20000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ST, 32'h18);
        rdc(WD, 32'h16);
        rdc(CF, 32'h03);
        wr(ST, 32'hFF);
        rdc(ST, 32'h1F);
        rdc(8'h3C, 32'h0);
        chk(32'(er), 32'h1);
        $display("register test done");
        wr(WD, 32'h0);
        waitfor(watchdog_reset);
        wr(WD, 32'h16);
        rdc(ST, 32'h0F);
        wr(swc_pkg::OFS_PERIPH_ENABLE_ONE, 32'h1);
        pulse;
        u_core.exec_sleep();
        cyc(1);
        chk(32'(sleep_nop), 32'h1);
        chk(32'(sleeping), 32'h0);
        rdc(ST, 32'h0F);
        $display("no-op test done");
        wr(FL, 32'h0);
        wr(IC, 32'h80);
        rdc(IC, 32'h81);
        u_core.exec_sleep();
        cyc(1);
        chk(32'(sleeping), 32'h1);
        chk(32'(cpu_clk_run), 32'h0);
        rdc(ST, 32'h17);
        pulse;
        waitfor(vector_load);
        chk(32'(vector_addr), 32'h4);
        rdc(ES, 32'h07);
        wr(swc_pkg::OFS_EVENT_MASK, 32'h02);
        cyc(2);
        chk(32'(irq), 32'h1);
        wr(ES, 32'h02);
        cyc(2);
        chk(32'(irq), 32'h0);
        rdc(ES, 32'h05);
        $display("wake test done");
        wr(FL, 32'h0);
        wr(IC, 32'h0);
        wr(CF, 32'h07);
        u_core.exec_sleep();
        pulse;
        k = 0;
        vec = 1'b0;
        repeat (40) begin
            @(negedge pclk);
            if (!sleeping && !cpu_clk_run) k++;
            vec = vec | vector_load;
        end
        chk(32'(k), 32'd8);
        chk(32'(vec), 32'h0);
        $display("start-up test done");
        wr(FL, 32'h0);
        wr(swc_pkg::OFS_PERIPH_ENABLE_ONE, 32'h0);
        wr(WD, 32'h0);
        u_core.exec_sleep();
        pulse;
        cyc(3);
        chk(32'(sleeping), 32'h1);
        waitfor(exec_prefetched);
        wr(WD, 32'h16);
        rdc(ST, 32'h07);
        u_core.exec_clear();
        rdc(ST, 32'h1F);
        for (k = 0; k < 4; k++) begin
            wr(CF, 32'(k));
            rdc(CF, 32'(k));
        end
        $display("watchdog test done");
        final_report;
    end
endmodule
`default_nettype wire
